// ### core/wt_pkg.sv
package wt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [7:0] WT_IDX_P0_WAKE = 8'hc5;
   localparam logic [7:0] WT_IDX_P2_WAKE = 8'hc6;
   localparam logic [7:0] WT_IDX_P3_WAKE = 8'hc7;
   localparam logic [7:0] WT_IDX_T2_CTRL = 8'hc8;
   localparam logic [7:0] WT_IDX_INT_STAT = 8'hca;
   localparam logic [7:0] WT_IDX_INT_MASK = 8'hcb;
   localparam logic [7:0] WT_IDX_PIN_LEVEL = 8'hcc;

   localparam int WT_ADDR_W = 12;

   ////////////////////////////////////////////////////////////////////////
   // timer-2 control field positions
   localparam int WT_T2_OVF_BIT = 7;
   localparam int WT_T2_EXT_BIT = 6;
   localparam int WT_RX_SEL_BIT = 5;
   localparam int WT_TX_SEL_BIT = 4;
   localparam int WT_EXT_EN_BIT = 3;

   // interrupt status / mask field positions
   localparam int WT_ST_T2_OVF = 0;
   localparam int WT_ST_T2_EXT = 1;
   localparam int WT_ST_WAKE_P0 = 2;
   localparam int WT_ST_WAKE_P2 = 3;
   localparam int WT_ST_WAKE_P3 = 4;
   localparam int WT_ST_W = 5;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] WT_WAKE_RST = 8'h00;
   localparam logic [7:0] WT_T2_CTRL_RST = 8'h00;
   localparam logic [WT_ST_W-1:0] WT_STAT_RST = 5'h00;
   localparam logic [WT_ST_W-1:0] WT_MASK_RST = 5'h00;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic {WT_IDLE, WT_ANSWER} wt_apb_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [WT_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } wt_apb_req_s;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } wt_apb_rsp_s;

   typedef struct packed {
      logic [7:0] p0;
      logic [7:0] p2;
      logic [7:0] p3;
   } wt_pins_s;

   typedef struct packed {
      logic overflow;
      logic ext_trigger;
      logic rx_select;
      logic tx_select;
      logic ext_pin_enable;
   } wt_t2_s;

   function automatic logic [WT_ADDR_W-1:0] wt_reg_addr(input logic [7:0] idx);
      wt_reg_addr = {2'h0, idx, 2'h0};
   endfunction : wt_reg_addr

endpackage : wt_pkg

// ### core/wt_sync.sv
`timescale 1ns/100ps
module wt_sync
   import wt_pkg::*;
#(
   parameter int W = 25
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] level_q,
   output logic [W-1:0] fall_q
);

   ////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second stage; edges come from two settled copies
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] level;
      logic [W-1:0] prev;
      logic [W-1:0] fall;
   } wt_sync_s;

   wt_sync_s s_q;
   wt_sync_s s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.meta = raw;
      s_d.level = s_q.meta;
      s_d.prev = s_q.level;
      // costs one more cycle of latency, but never reads a possibly metastable stage
      s_d.fall = s_q.prev & ~s_q.level;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         // idle pins read high so release of reset makes no false edge
         s_q <= '{meta: '1, level: '1, prev: '1, fall: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign level_q = s_q.level;
   assign fall_q = s_q.fall;

endmodule : wt_sync

// ### core/wt_clksel.sv
`timescale 1ns/100ps
module wt_clksel
   import wt_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic timer1_overflow,
   input wire logic timer2_overflow,
   input wire logic rx_select,
   input wire logic tx_select,
   output logic uart_rx_tick_q,
   output logic uart_tx_tick_q
);

   ////////////////////////////////////////////////////////////////////////
   // ticks are registered, so the serial port sees them one cycle late
   typedef struct packed {
      logic rx_tick;
      logic tx_tick;
   } wt_clksel_s;

   wt_clksel_s s_q;
   wt_clksel_s s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.rx_tick = rx_select ? timer2_overflow : timer1_overflow; // R6
      s_d.tx_tick = tx_select ? timer2_overflow : timer1_overflow; // R7
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign uart_rx_tick_q = s_q.rx_tick;
   assign uart_tx_tick_q = s_q.tx_tick;

endmodule : wt_clksel

// ### core/wt_top.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
// Summary of operation
// R1 - port 0 mask: a 1 lets that pin wake the chip and interrupt
// R2 - port 2 mask: a 1 lets that pin wake the chip and interrupt
// R3 - port 3 mask: a 1 lets that pin wake the chip and interrupt
// R4 - overflow flag set on timer-2 overflow unless timer 2 clocks serial port
// R5 - with pin enable set, external falling edge sets edge flag; software clears
// R6 - receive clock select: 0 takes timer 1 overflow, 1 timer 2 overflow
// R7 - transmit clock select: 0 takes timer 1 overflow, 1 timer 2 overflow
// R8 - hardware set beats a software clear in the same cycle
module wt_top
   import wt_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wt_apb_req_s apb_req,
   output wt_apb_rsp_s apb_rsp,
   input wt_pins_s port_pins,
   input wire logic timer2_ext_pin,
   input wire logic timer1_overflow,
   input wire logic timer2_overflow,
   output wt_t2_s timer2_status,
   output logic timer2_ext_trigger_q,
   output logic uart_rx_tick_q,
   output logic uart_tx_tick_q,
   output logic wake_q,
   output logic irq_q
);

   ////////////////////////////////////////////////////////////////////////
   // whole state of the block
   typedef struct packed {
      wt_apb_e apb_state;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [WT_ST_W-1:0] stat_read;
      logic read_stat;
      logic [7:0] port0_wake_enable;
      logic [7:0] port2_wake_enable;
      logic [7:0] port3_wake_enable;
      logic timer2_overflow_flag;
      logic timer2_ext_edge_flag;
      logic uart_rx_clock_select;
      logic uart_tx_clock_select;
      logic timer2_ext_pin_enable;
      logic ext_trigger;
      logic [WT_ST_W-1:0] int_stat;
      logic [WT_ST_W-1:0] int_mask;
      logic wake;
      logic irq;
   } wt_state_s;

   localparam wt_state_s WT_STATE_RST = '{
      apb_state: WT_IDLE,
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: 32'h0000_0000,
      stat_read: WT_STAT_RST,
      read_stat: 1'b0,
      port0_wake_enable: WT_WAKE_RST,
      port2_wake_enable: WT_WAKE_RST,
      port3_wake_enable: WT_WAKE_RST,
      timer2_overflow_flag: WT_T2_CTRL_RST[WT_T2_OVF_BIT],
      timer2_ext_edge_flag: WT_T2_CTRL_RST[WT_T2_EXT_BIT],
      uart_rx_clock_select: WT_T2_CTRL_RST[WT_RX_SEL_BIT],
      uart_tx_clock_select: WT_T2_CTRL_RST[WT_TX_SEL_BIT],
      timer2_ext_pin_enable: WT_T2_CTRL_RST[WT_EXT_EN_BIT],
      ext_trigger: 1'b0,
      int_stat: WT_STAT_RST,
      int_mask: WT_MASK_RST,
      wake: 1'b0,
      irq: 1'b0
   };

   wt_state_s s_q;
   wt_state_s s_d;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; pins arrive from pads, outside the clock domain
   logic [24:0] pin_level;
   logic [24:0] pin_fall;
   wt_pins_s pins_lvl;
   wt_pins_s pins_fall;
   logic ext_fall;

   wt_sync #(
      .W(25)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw({timer2_ext_pin, port_pins}),
      .level_q(pin_level),
      .fall_q(pin_fall)
   );

   assign pins_lvl = pin_level[23:0];
   assign pins_fall = pin_fall[23:0];
   assign ext_fall = pin_fall[24];

   ////////////////////////////////////////////////////////////////////////
   // serial port clock selection
   wt_clksel u_clksel (
      .clk(clk),
      .sys_rst(sys_rst),
      .timer1_overflow(timer1_overflow),
      .timer2_overflow(timer2_overflow),
      .rx_select(s_q.uart_rx_clock_select),
      .tx_select(s_q.uart_tx_clock_select),
      .uart_rx_tick_q(uart_rx_tick_q),
      .uart_tx_tick_q(uart_tx_tick_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic port_event(input logic [7:0] fall, input logic [7:0] en);
      port_event = |(fall & en);
   endfunction : port_event

   function automatic logic port_wake(input logic [7:0] level, input logic [7:0] en);
      // a pin low while enabled holds the wake request
      port_wake = |(~level & en);
   endfunction : port_wake

   function automatic logic [7:0] t2_ctrl_word(input wt_state_s s);
      logic [7:0] w;
      w = 8'h00;
      w[WT_T2_OVF_BIT] = s.timer2_overflow_flag;
      w[WT_T2_EXT_BIT] = s.timer2_ext_edge_flag;
      w[WT_RX_SEL_BIT] = s.uart_rx_clock_select;
      w[WT_TX_SEL_BIT] = s.uart_tx_clock_select;
      w[WT_EXT_EN_BIT] = s.timer2_ext_pin_enable;
      t2_ctrl_word = w;
   endfunction : t2_ctrl_word

   ////////////////////////////////////////////////////////////////////////
   // combinational next state
   logic setup;
   logic finish;
   logic hit;
   logic [31:0] rdata;
   logic ovf_set;
   logic ext_set;
   logic [WT_ST_W-1:0] ev;
   logic [WT_ST_W-1:0] stat_clr;

   always_comb
   begin
      s_d = s_q;
      setup = apb_req.psel & ~apb_req.penable & (s_q.apb_state == WT_IDLE);
      finish = apb_req.psel & apb_req.penable & s_q.pready;
      hit = 1'b1;
      rdata = 32'h0000_0000;

      // address decode for reads, done in the setup cycle
      case (apb_req.paddr)
         wt_reg_addr(WT_IDX_P0_WAKE):
         begin
            rdata[7:0] = s_q.port0_wake_enable;
         end
         wt_reg_addr(WT_IDX_P2_WAKE):
         begin
            rdata[7:0] = s_q.port2_wake_enable;
         end
         wt_reg_addr(WT_IDX_P3_WAKE):
         begin
            rdata[7:0] = s_q.port3_wake_enable;
         end
         wt_reg_addr(WT_IDX_T2_CTRL):
         begin
            rdata[7:0] = t2_ctrl_word(s_q);
         end
         wt_reg_addr(WT_IDX_INT_STAT):
         begin
            rdata[WT_ST_W-1:0] = s_q.int_stat;
         end
         wt_reg_addr(WT_IDX_INT_MASK):
         begin
            rdata[WT_ST_W-1:0] = s_q.int_mask;
         end
         wt_reg_addr(WT_IDX_PIN_LEVEL):
         begin
            rdata[23:0] = pins_lvl;
         end
         default:
         begin
            hit = 1'b0;
         end
      endcase

      // hardware events
      ovf_set = timer2_overflow & ~(s_q.uart_rx_clock_select | s_q.uart_tx_clock_select); // R4
      ext_set = ext_fall & s_q.timer2_ext_pin_enable; // R5
      ev = '0;
      ev[WT_ST_T2_OVF] = ovf_set;
      ev[WT_ST_T2_EXT] = ext_set;
      ev[WT_ST_WAKE_P0] = port_event(pins_fall.p0, s_q.port0_wake_enable); // R1
      ev[WT_ST_WAKE_P2] = port_event(pins_fall.p2, s_q.port2_wake_enable); // R2
      ev[WT_ST_WAKE_P3] = port_event(pins_fall.p3, s_q.port3_wake_enable); // R3

      // apb slave: zero wait states, answer registered one cycle after setup
      stat_clr = '0;
      case (s_q.apb_state)
         WT_IDLE:
         begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            if (setup)
            begin
               s_d.apb_state = WT_ANSWER;
               s_d.pready = 1'b1;
               s_d.pslverr = ~hit;
               s_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
               s_d.read_stat = ~apb_req.pwrite & (apb_req.paddr == wt_reg_addr(WT_IDX_INT_STAT));
               s_d.stat_read = s_q.int_stat;
            end
         end
         WT_ANSWER:
         begin
            if (finish)
            begin
               s_d.apb_state = WT_IDLE;
               s_d.pready = 1'b0;
               s_d.pslverr = 1'b0;
               s_d.read_stat = 1'b0;
               // only bits the reader actually saw are cleared
               if (s_q.read_stat)
               begin
                  stat_clr = s_q.stat_read;
               end
               if (apb_req.pwrite & ~s_q.pslverr)
               begin
                  case (apb_req.paddr)
                     wt_reg_addr(WT_IDX_P0_WAKE):
                     begin
                        s_d.port0_wake_enable = apb_req.pwdata[7:0]; // R1
                     end
                     wt_reg_addr(WT_IDX_P2_WAKE):
                     begin
                        s_d.port2_wake_enable = apb_req.pwdata[7:0]; // R2
                     end
                     wt_reg_addr(WT_IDX_P3_WAKE):
                     begin
                        s_d.port3_wake_enable = apb_req.pwdata[7:0]; // R3
                     end
                     wt_reg_addr(WT_IDX_T2_CTRL):
                     begin
                        s_d.timer2_overflow_flag = apb_req.pwdata[WT_T2_OVF_BIT];
                        s_d.timer2_ext_edge_flag = apb_req.pwdata[WT_T2_EXT_BIT];
                        s_d.uart_rx_clock_select = apb_req.pwdata[WT_RX_SEL_BIT]; // R6
                        s_d.uart_tx_clock_select = apb_req.pwdata[WT_TX_SEL_BIT]; // R7
                        s_d.timer2_ext_pin_enable = apb_req.pwdata[WT_EXT_EN_BIT];
                     end
                     wt_reg_addr(WT_IDX_INT_MASK):
                     begin
                        s_d.int_mask = apb_req.pwdata[WT_ST_W-1:0];
                     end
                     default:
                     begin
                        // status and pin level are read only
                        s_d.int_mask = s_q.int_mask;
                     end
                  endcase
               end
            end
         end
         default:
         begin
            s_d.apb_state = WT_IDLE;
            s_d.pready = 1'b0;
         end
      endcase

      // flags: set after the software write, so a same-cycle event survives
      if (ovf_set)
      begin
         s_d.timer2_overflow_flag = 1'b1; // R4 R8
      end
      if (ext_set)
      begin
         s_d.timer2_ext_edge_flag = 1'b1; // R5 R8
      end

      // sticky status, read clear loses to a new event
      s_d.int_stat = (s_q.int_stat & ~stat_clr) | ev; // R8

      // capture/reload request toward the timer datapath
      s_d.ext_trigger = ext_set; // R5

      s_d.wake = port_wake(pins_lvl.p0, s_q.port0_wake_enable) // R1
         | port_wake(pins_lvl.p2, s_q.port2_wake_enable) // R2
         | port_wake(pins_lvl.p3, s_q.port3_wake_enable); // R3

      // registered, so irq trails the status bit by one cycle
      s_d.irq = |(s_q.int_stat & s_q.int_mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_q <= WT_STATE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register
   assign apb_rsp.pready = s_q.pready;
   assign apb_rsp.prdata = s_q.prdata;
   assign apb_rsp.pslverr = s_q.pslverr;
   assign timer2_status.overflow = s_q.timer2_overflow_flag;
   assign timer2_status.ext_trigger = s_q.timer2_ext_edge_flag;
   assign timer2_status.rx_select = s_q.uart_rx_clock_select;
   assign timer2_status.tx_select = s_q.uart_tx_clock_select;
   assign timer2_status.ext_pin_enable = s_q.timer2_ext_pin_enable;
   assign timer2_ext_trigger_q = s_q.ext_trigger;
   assign wake_q = s_q.wake;
   assign irq_q = s_q.irq;

endmodule : wt_top

// ### tb/wt_checker.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// port-level checks of the flag and register bank
module wt_checker
   import wt_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wt_apb_req_s apb_req,
   input wt_apb_rsp_s apb_rsp,
   input wt_pins_s port_pins,
   input wire logic timer2_ext_pin,
   input wire logic timer1_overflow,
   input wire logic timer2_overflow,
   input wt_t2_s timer2_status,
   input wire logic timer2_ext_trigger_q,
   input wire logic uart_rx_tick_q,
   input wire logic uart_tx_tick_q,
   input wire logic wake_q,
   input wire logic irq_q
);
   logic ctrl_wr;
   // a software write is the only other way a flag may move
   assign ctrl_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
      && apb_req.paddr == {2'h0, WT_IDX_T2_CTRL, 2'h0};
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   chk_ovf_sets: assert property (timer2_overflow && !timer2_status.rx_select
      && !timer2_status.tx_select |=> timer2_status.overflow) else $error("overflow flag not set");
   chk_ovf_cause: assert property ($rose(timer2_status.overflow) |->
      $past(timer2_overflow && !timer2_status.rx_select && !timer2_status.tx_select) || $past(ctrl_wr))
      else $error("overflow flag set without cause");
   chk_ovf_holds: assert property (timer2_status.overflow && !ctrl_wr |=> timer2_status.overflow)
      else $error("overflow flag dropped");
   chk_ext_holds: assert property (timer2_status.ext_trigger && !ctrl_wr |=> timer2_status.ext_trigger)
      else $error("edge flag dropped");
   chk_ext_trig: assert property (timer2_ext_trigger_q |-> $past(timer2_status.ext_pin_enable)
      ##[0:1] timer2_status.ext_trigger) else $error("edge trigger without enable or flag");
   chk_rx_tick: assert property (uart_rx_tick_q ==
      $past(timer2_status.rx_select ? timer2_overflow : timer1_overflow)) else $error("receive tick wrong");
   chk_tx_tick: assert property (uart_tx_tick_q ==
      $past(timer2_status.tx_select ? timer2_overflow : timer1_overflow)) else $error("transmit tick wrong");
   chk_wake_idle: assert property ((&port_pins)[*3] |=> !wake_q)
      else $error("wake with all pins high");
   chk_apb_answer: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("bus answer not one cycle");
endmodule : wt_checker

bind wt_top wt_checker chk (.clk, .sys_rst, .apb_req, .apb_rsp, .port_pins, .timer2_ext_pin, .timer1_overflow,
   .timer2_overflow, .timer2_status, .timer2_ext_trigger_q, .uart_rx_tick_q, .uart_tx_tick_q, .wake_q, .irq_q);

// ### tb/wt_cpu.sv
`timescale 1ns/100ps
// cpu side of the register bus, one request at a time
module wt_cpu
   import wt_pkg::*;
(
   input wire logic clk,
   output wt_apb_req_s req,
   input wt_apb_rsp_s rsp
);
   initial req = '0;
   // request held whole until pready is seen at an edge, so no wait-state guess
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
      @(posedge clk);
      req.penable <= 1'b1;
      // only the bench watchdog ends a wait that never sees pready
      do
      begin
         @(posedge clk);
      end
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask : xfer
endmodule : wt_cpu

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
   import wt_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   wt_apb_req_s apb_req;
   wt_apb_rsp_s apb_rsp;
   // pins idle high so the preset synchroniser sees no false edge
   wt_pins_s port_pins = '1;
   logic timer2_ext_pin = 1'b1;
   logic timer1_overflow = 1'b0;
   logic timer2_overflow = 1'b0;
   wt_t2_s timer2_status;
   logic timer2_ext_trigger_q;
   logic uart_rx_tick_q;
   logic uart_tx_tick_q;
   logic wake_q;
   logic irq_q;
   logic [31:0] rd;
   logic err;
   int fail_count = 0;
   int n_compared = 0;
   logic [7:0] wk[3] = '{WT_IDX_P0_WAKE, WT_IDX_P2_WAKE, WT_IDX_P3_WAKE};

   always #10 clk = ~clk;

   wt_cpu cpu (.clk, .req(apb_req), .rsp(apb_rsp));
   wt_top dut (.clk, .sys_rst, .apb_req, .apb_rsp, .port_pins, .timer2_ext_pin, .timer1_overflow,
      .timer2_overflow, .timer2_status, .timer2_ext_trigger_q, .uart_rx_tick_q, .uart_tx_tick_q, .wake_q, .irq_q);

   ////////////////////////////////////////////////////////////
   task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : ck

   task automatic rreg(input logic [7:0] idx, input logic [31:0] exp);
      cpu.xfer(1'b0, idx, 32'h0, rd, err);
      ck(rd, exp, "register read");
   endtask : rreg

   task automatic wreg(input logic [7:0] idx, input logic [31:0] wd);
      cpu.xfer(1'b1, idx, wd, rd, err);
   endtask : wreg

   task automatic pin_low(input int p, input int b);
      @(posedge clk) port_pins <= port_pins & ~(24'h1 << ((2 - p) * 8 + b));
      repeat (6) @(posedge clk);
   endtask : pin_low

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   initial
   begin
      repeat (3000) @(posedge clk);
      fail_count++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test();
   end

   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         rreg(wk[i], 32'h0);
         wreg(wk[i], 32'h5a + i);
         rreg(wk[i], 32'h5a + i);
      end
      rreg(WT_IDX_T2_CTRL, 32'h0);
      cpu.xfer(1'b0, 8'h3f, 32'h0, rd, err);
      ck({31'h0, err}, 32'h1, "unmapped error");
      $display("test registers done");
      wreg(WT_IDX_INT_MASK, 32'h1c);
      for (int i = 0; i < 3; i++)
      begin
         pin_low(i, 5);
         ck({31'h0, wake_q}, 32'h0, "disabled pin");
         pin_low(i, 3);
         ck({30'h0, wake_q, irq_q}, 32'h3, "enabled pin");
         rreg(WT_IDX_INT_STAT, 32'h1 << (2 + i));
         @(posedge clk) port_pins <= '1;
         repeat (4) @(posedge clk);
         ck({30'h0, wake_q, irq_q}, 32'h0, "pins released");
      end
      $display("test wake done");
      @(posedge clk) timer2_overflow <= 1'b1;
      @(posedge clk) timer2_overflow <= 1'b0;
      rreg(WT_IDX_T2_CTRL, 32'h80);
      wreg(WT_IDX_T2_CTRL, 32'h0);
      rreg(WT_IDX_T2_CTRL, 32'h0);
      for (int s = 1; s < 4; s++)
      begin
         wreg(WT_IDX_T2_CTRL, s << 4);
         @(posedge clk) timer1_overflow <= 1'b1;
         @(posedge clk) timer1_overflow <= 1'b0;
         @(posedge clk) timer2_overflow <= 1'b1;
         ck({30'h0, uart_rx_tick_q, uart_tx_tick_q}, 32'(~s & 3), "timer 1 tick");
         @(posedge clk) timer2_overflow <= 1'b0;
         @(posedge clk);
         ck({30'h0, uart_rx_tick_q, uart_tx_tick_q}, 32'(s), "timer 2 tick");
         rreg(WT_IDX_T2_CTRL, s << 4);
      end
      rreg(WT_IDX_INT_STAT, 32'h1);
      $display("test overflow done");
      for (int e = 1; e >= 0; e--)
      begin
         wreg(WT_IDX_T2_CTRL, e << 3);
         @(posedge clk) timer2_ext_pin <= 1'b0;
         repeat (6) @(posedge clk);
         rreg(WT_IDX_T2_CTRL, e * 32'h48);
         @(posedge clk) timer2_ext_pin <= 1'b1;
         repeat (4) @(posedge clk);
      end
      // overflow lands on the very edge that the clearing write takes effect
      fork
         wreg(WT_IDX_T2_CTRL, 32'h0);
         begin
            repeat (2) @(posedge clk);
            timer2_overflow <= 1'b1;
            @(posedge clk) timer2_overflow <= 1'b0;
         end
      join
      rreg(WT_IDX_T2_CTRL, 32'h80);
      rreg(WT_IDX_INT_STAT, 32'h3);
      $display("test flags done");
      stop_test();
   end
endmodule : tb
